// file: shared/ecsh_pkg.sv
// package: encoder control/status handshake types and constants
package ecsh_pkg;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          ECSH_WORD_W   = 16;
    localparam int          ECSH_POS_W    = 32;
    localparam int          ECSH_NUM_FN   = 4;
    localparam logic [15:0] ECSH_CTRL_RST = 16'h0000;
    localparam logic [15:0] ECSH_STAT_RST = 16'h0000;
    localparam logic [31:0] ECSH_POS_ZERO = 32'h0000_0000;
    // bits 8..12 of the control word carry nothing
    localparam logic [15:0] ECSH_CTRL_USED = 16'hE0FF;

    // ------------------------------------------------------------
    // command field of the control word
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ECSH_CMD_NONE = 3'b000,
        ECSH_CMD_ACT  = 3'b001,
        ECSH_CMD_READ = 3'b010,
        ECSH_CMD_STOP = 3'b011
    } ecsh_cmd_e;

    // ------------------------------------------------------------
    // word layouts, msb first
    // ------------------------------------------------------------
    typedef struct packed {
        logic       ack;
        logic       park;
        logic       cyc;
        logic [4:0] rsv;
        logic       flying;
        logic [2:0] cmd;
        logic [3:0] sel;
    } ecsh_ctrl_s;

    typedef struct packed {
        logic       fault;
        logic       parked;
        logic       cyc;
        logic       rsv12;
        logic       ack_act;
        logic       rsv10;
        logic [1:0] probe;
        logic [3:0] ready;
        logic [3:0] active;
    } ecsh_stat_s;

endpackage

// file: core/ecsh_meas.sv
// one measurement function: arms, captures a position on its event, holds the value
`timescale 1ns/10ps
`default_nettype none
module ecsh_meas (
    // clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    // commands
    input  wire logic                           arm,
    input  wire logic                           stop,
    input  wire logic                           flying,
    // events
    input  wire logic                           ref_evt,
    input  wire logic                           probe_evt,
    input  wire logic [ecsh_pkg::ECSH_POS_W-1:0] position,
    // state
    output logic                                active,
    output logic                                ready,
    output logic [ecsh_pkg::ECSH_POS_W-1:0]     value
);
    import ecsh_pkg::*;

    logic                  active_q;
    logic                  ready_q;
    logic                  flying_q;
    logic [ECSH_POS_W-1:0] value_q;
    wire                   evt     = flying_q ? probe_evt : ref_evt;
    wire                   capture = active_q & evt & ~arm & ~stop;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_q <= 1'b0;
            ready_q  <= 1'b0;
            flying_q <= 1'b0;
            value_q  <= ECSH_POS_ZERO;
        end else begin
            if (arm) begin
                flying_q <= flying;
            end
            // a capture is one-shot: the function drops out once it has its value
            active_q <= arm | (active_q & ~stop & ~capture);
            // capture sets, arm or stop clears; arm or stop wins, as either one blocks the capture
            ready_q  <= capture | (ready_q & ~arm & ~stop);
            if (capture) begin
                value_q <= position;
            end
        end
    end

    assign active = active_q;
    assign ready  = ready_q;
    assign value  = value_q;
endmodule // ecsh_meas
`default_nettype wire

// file: core/ecsh_top.sv
// encoder control word decode and encoder status word generation for encoder channel 1
// Functional notes
// RULE_01 - The controller picks the functions to act on with a one in control bits 0 to 3.
// RULE_02 - The controller uses control bits 4 to 6 to start, stop or read back the picked functions.
// RULE_03 - The command field decodes into no function, activate, read generated value and interrupt.
// RULE_04 - Control bit 7 at one arms flying probe measurement, at zero a reference mark search.
// RULE_05 - Control bit 13 at one sends the absolute position cyclically in the second position word.
// RULE_06 - Control bit 14 at one parks the encoder.
// RULE_07 - Control bit 15 is the controller's acknowledgement of an encoder fault.
// RULE_08 - Status bits 0 to 3 show which measurement functions 1 to 4 are active.
// RULE_09 - Functions 1 to 4 use reference marks 1 to 4, or two edges each of probe 1 and probe 2.
// RULE_10 - Status bits 4 to 7 show that a captured value of function 1 to 4 can be read.
// RULE_11 - Status bits 8 and 9 follow the high level of probe 1 and probe 2.
// RULE_12 - Status bit 11 is one while a fault acknowledgement is in progress.
// RULE_13 - Status bit 13 confirms that the absolute value is being sent cyclically.
// RULE_14 - Status bit 14 is one while the encoder is parked.
// RULE_15 - On an encoder fault status bit 15 is set and the fault code replaces the position word.
// RULE_16 - Control bits 8 to 12 and status bits 10 and 12 have no function.
// RULE_17 - Reserved status bits read zero and reserved control bits are ignored.
`timescale 1ns/10ps
`default_nettype none
module ecsh_top (
    // clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            rst,
    // cyclic telegram from the controller
    input  wire logic [ecsh_pkg::ECSH_WORD_W-1:0] encoder_control_word,
    input  wire logic                            ctrl_valid,
    // encoder side
    input  wire logic [ecsh_pkg::ECSH_POS_W-1:0]  position,
    input  wire logic [ecsh_pkg::ECSH_NUM_FN-1:0] ref_mark,
    input  wire logic                            probe1,
    input  wire logic                            probe2,
    input  wire logic                            enc_fault,
    input  wire logic [ecsh_pkg::ECSH_POS_W-1:0]  fault_code,
    // answer telegram
    output var ecsh_pkg::ecsh_stat_s             encoder_status_word,
    output logic [ecsh_pkg::ECSH_POS_W-1:0]       second_position_actual_value,
    output logic                                 encoder_park
);
    import ecsh_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // lowest set bit as one-hot; read-back shows one function at a time
    function automatic logic [ECSH_NUM_FN-1:0] lowest_one(input logic [ECSH_NUM_FN-1:0] v);
        lowest_one = v & (~v + 4'h1);
    endfunction

    // ------------------------------------------------------------
    // control word register
    // ------------------------------------------------------------
    ecsh_ctrl_s ctrl_q;
    ecsh_ctrl_s ctrl_d;
    assign ctrl_d = ecsh_ctrl_s'(encoder_control_word & ECSH_CTRL_USED); // RULE_16 RULE_17

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= ecsh_ctrl_s'(ECSH_CTRL_RST);
        end else if (ctrl_valid) begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // commands act once per telegram, on the strobe; read-back is a level
    ecsh_cmd_e cmd;
    logic      cmd_act;
    logic      cmd_stop;
    assign cmd = ecsh_cmd_e'(ctrl_d.cmd); // RULE_02

    always_comb begin
        cmd_act  = 1'b0;
        cmd_stop = 1'b0;
        unique case (cmd) // RULE_03
            ECSH_CMD_NONE: ;
            ECSH_CMD_ACT:  cmd_act  = ctrl_valid;
            ECSH_CMD_READ: ;
            ECSH_CMD_STOP: cmd_stop = ctrl_valid;
            default: ;
        endcase
    end

    wire [ECSH_NUM_FN-1:0] arm_v  = {ECSH_NUM_FN{cmd_act}} & ctrl_d.sel;  // RULE_01
    wire [ECSH_NUM_FN-1:0] stop_v = {ECSH_NUM_FN{cmd_stop}} & ctrl_d.sel; // RULE_01
    wire                   rd_cmd = ecsh_cmd_e'(ctrl_q.cmd) == ECSH_CMD_READ;

    // ------------------------------------------------------------
    // probe edges and parking
    // ------------------------------------------------------------
    logic probe1_q;
    logic probe2_q;
    wire  parked = ctrl_q.park; // RULE_06
    // parked encoder delivers no events, so nothing is captured meanwhile
    wire [ECSH_NUM_FN-1:0] probe_ev = {probe2_q & ~probe2, ~probe2_q & probe2,
                                       probe1_q & ~probe1, ~probe1_q & probe1} & {ECSH_NUM_FN{~parked}}; // RULE_09
    wire [ECSH_NUM_FN-1:0] ref_ev   = ref_mark & {ECSH_NUM_FN{~parked}}; // RULE_09

    always_ff @(posedge core_clk) begin
        if (rst) begin
            probe1_q <= 1'b0;
            probe2_q <= 1'b0;
        end else begin
            probe1_q <= probe1;
            probe2_q <= probe2;
        end
    end

    // ------------------------------------------------------------
    // measurement functions
    // ------------------------------------------------------------
    logic [ECSH_NUM_FN-1:0] fn_active;
    logic [ECSH_NUM_FN-1:0] fn_ready;
    logic [ECSH_POS_W-1:0]  fn_value [ECSH_NUM_FN];

    for (genvar i = 0; i < ECSH_NUM_FN; i++) begin : g_fn
        ecsh_meas u_meas (
            .core_clk  (core_clk),
            .rst       (rst),
            .arm       (arm_v[i]),
            .stop      (stop_v[i]),
            .flying    (ctrl_d.flying), // RULE_04
            .ref_evt   (ref_ev[i]),
            .probe_evt (probe_ev[i]),
            .position  (position),
            .active    (fn_active[i]),
            .ready     (fn_ready[i]),
            .value     (fn_value[i])
        );
    end

    wire [ECSH_NUM_FN-1:0] rd_pick = lowest_one(ctrl_q.sel & fn_ready);
    logic [ECSH_POS_W-1:0] rd_value;
    always_comb begin
        rd_value = ECSH_POS_ZERO;
        for (int k = 0; k < ECSH_NUM_FN; k++) begin
            if (rd_pick[k]) begin
                rd_value = fn_value[k];
            end
        end
    end

    // ------------------------------------------------------------
    // encoder fault and acknowledgement
    // ------------------------------------------------------------
    logic                  fault_q;
    logic [ECSH_POS_W-1:0] code_q;
    wire                   fault_new = enc_fault & ~parked;
    wire                   ack_act   = ctrl_q.ack & fault_q; // RULE_07

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fault_q <= 1'b0;
            code_q  <= ECSH_POS_ZERO;
        end else begin
            // a fault still present keeps the flag up against the acknowledgement
            fault_q <= fault_new | (fault_q & ~ack_act); // RULE_07 RULE_15
            if (fault_new) begin
                code_q <= fault_code;
            end
        end
    end

    // ------------------------------------------------------------
    // answer telegram
    // ------------------------------------------------------------
    ecsh_stat_s            stat_d;
    ecsh_stat_s            stat_q;
    logic [ECSH_POS_W-1:0] xist_d;
    logic [ECSH_POS_W-1:0] xist_q;
    wire                   cyc_on = ctrl_q.cyc & ~parked & ~fault_q;

    always_comb begin
        stat_d         = ecsh_stat_s'(ECSH_STAT_RST); // RULE_16 RULE_17
        stat_d.active  = fn_active;                   // RULE_08
        stat_d.ready   = fn_ready;                    // RULE_10
        stat_d.probe   = {probe2, probe1};            // RULE_11
        stat_d.ack_act = ack_act;                     // RULE_12
        stat_d.cyc     = cyc_on;                      // RULE_13
        stat_d.parked  = parked;                      // RULE_14
        stat_d.fault   = fault_q;                     // RULE_15
    end

    // fault code has priority, then a requested read-back, then the cyclic value
    assign xist_d = fault_q          ? code_q   : // RULE_15
                    (rd_cmd && |rd_pick) ? rd_value : // RULE_10
                    cyc_on           ? position : ECSH_POS_ZERO; // RULE_05

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_q <= ecsh_stat_s'(ECSH_STAT_RST);
            xist_q <= ECSH_POS_ZERO;
        end else begin
            stat_q <= stat_d;
            xist_q <= xist_d;
        end
    end

    assign encoder_status_word          = stat_q;
    assign second_position_actual_value = xist_q;
    assign encoder_park                 = parked;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_arm_one;
        ctrl_valid && ctrl_d.cmd == ECSH_CMD_ACT && ctrl_d.sel[0];
    endsequence
    property p_arm_shows_active;
        s_arm_one ##1 1'b1 |=> encoder_status_word.active[0] && !encoder_status_word.ready[0];
    endproperty
    a_arm_shows_active: assert property (p_arm_shows_active) else $error("activate did not show active"); // RULE_08

    property p_stop_clears;
        ctrl_valid && ctrl_d.cmd == ECSH_CMD_STOP && ctrl_d.sel[1]
            |-> ##2 !encoder_status_word.active[1] && !encoder_status_word.ready[1];
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("interrupt left function running"); // RULE_03

    property p_ref_capture;
        // the mode latched at activation decides, not the mode bit of a later telegram
        fn_active[2] && !g_fn[2].u_meas.flying_q && ref_mark[2] && !parked && !arm_v[2] && !stop_v[2]
            |-> ##2 encoder_status_word.ready[2] && !encoder_status_word.active[2];
    endproperty
    a_ref_capture: assert property (p_ref_capture) else $error("reference mark not captured"); // RULE_09

    property p_probe_mirror;
        ##1 encoder_status_word.probe == $past({probe2, probe1});
    endproperty
    a_probe_mirror: assert property (p_probe_mirror) else $error("probe bits do not follow inputs"); // RULE_11

    property p_fault_code;
        enc_fault && !parked |-> ##2 encoder_status_word.fault && second_position_actual_value == $past(fault_code, 2);
    endproperty
    a_fault_code: assert property (p_fault_code) else $error("fault code not in position word"); // RULE_15

    property p_ack_bit;
        ctrl_q.ack && fault_q |=> encoder_status_word.ack_act;
    endproperty
    a_ack_bit: assert property (p_ack_bit) else $error("acknowledge in progress not shown"); // RULE_12

    property p_park;
        ctrl_valid && ctrl_d.park |=> encoder_park ##1 encoder_status_word.parked && !encoder_status_word.cyc;
    endproperty
    a_park: assert property (p_park) else $error("park request not answered"); // RULE_14

    property p_cyclic;
        cyc_on && !fault_q && !rd_cmd |=> encoder_status_word.cyc && second_position_actual_value == $past(position);
    endproperty
    a_cyclic: assert property (p_cyclic) else $error("cyclic absolute value not sent"); // RULE_05 RULE_13

    property p_reserved;
        !encoder_status_word.rsv10 && !encoder_status_word.rsv12 && ctrl_q.rsv == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // RULE_16 RULE_17
endmodule // ecsh_top
`default_nettype wire

// file: dv/ecsh_ctrl_model.sv
// controller-side model: sends encoder control words as one-cycle telegrams
`timescale 1ns/10ps
`default_nettype none
module ecsh_ctrl_model (
    // clock
    input  wire logic                            core_clk,
    // telegram to the drive
    output var logic [ecsh_pkg::ECSH_WORD_W-1:0] encoder_control_word,
    output var logic                             ctrl_valid
);
    import ecsh_pkg::*;

    initial begin
        encoder_control_word = ECSH_CTRL_RST;
        ctrl_valid = 1'b0;
    end

    // word is inverted once valid drops, so a design reading it unqualified shows up
    task automatic send(input ecsh_ctrl_s w);
        @(negedge core_clk);
        encoder_control_word = w;
        ctrl_valid = 1'b1;
        @(negedge core_clk);
        ctrl_valid = 1'b0;
        encoder_control_word = ~16'(w);
    endtask
endmodule // ecsh_ctrl_model
`default_nettype wire

// file: dv/ecsh_top_tb.sv
// self-checking bench for the encoder control/status handshake
`timescale 1ns/10ps
`default_nettype none
module ecsh_top_tb;
    import ecsh_pkg::*;
    typedef struct {
        int          cyc;
        logic [15:0] sm;
        logic [15:0] sv;
        logic        pe;
        logic [31:0] pv;
        logic        kv;
    } ecsh_exp_s;

    logic        core_clk = 1'b0;
    logic        rst;
    logic [15:0] word;
    logic        vld;
    logic [31:0] position;
    logic [3:0]  ref_mark;
    logic        probe1;
    logic        probe2;
    logic        enc_fault;
    logic [31:0] fault_code;
    logic [15:0] st;
    logic [31:0] pos;
    logic        park;
    logic        parked;
    logic [31:0] cap;
    logic [3:0]  sel;
    int          failures;
    int          cmp_count;
    int          cyc;
    int          k;
    ecsh_exp_s   exq[$];
    ecsh_exp_s   e;

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    ecsh_ctrl_model u_ecsh_ctrl_model (
        .core_clk             (core_clk),
        .encoder_control_word (word),
        .ctrl_valid           (vld)
    );

    ecsh_top u_ecsh_top (
        .core_clk                     (core_clk),
        .rst                          (rst),
        .encoder_control_word         (word),
        .ctrl_valid                   (vld),
        .position                     (position),
        .ref_mark                     (ref_mark),
        .probe1                       (probe1),
        .probe2                       (probe2),
        .enc_fault                    (enc_fault),
        .fault_code                   (fault_code),
        .encoder_status_word          (st),
        .second_position_actual_value (pos),
        .encoder_park                 (park)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic expect_at(input int d, input logic [15:0] m, input logic [15:0] v,
                             input logic pe, input logic [31:0] pv);
        exq.push_back('{cyc + d, m, v, pe, pv, parked});
    endtask

    function automatic ecsh_ctrl_s mk(input logic a, input logic p, input logic c,
                                      input logic f, input ecsh_cmd_e cmd, input logic [3:0] s);
        return '{a, p, c, 5'($urandom), f, cmd, s};
    endfunction

    // idle cycle first so every pending check lands before the next word is taken
    task automatic tx(input ecsh_ctrl_s w);
        @(negedge core_clk);
        u_ecsh_ctrl_model.send(w);
        k = cyc;
    endtask

    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        while (st[b] !== v && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        chk("status bit", 32'(v), 32'(st[b]));
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(negedge core_clk) begin
        while (exq.size() > 0 && exq[0].cyc <= cyc) begin
            e = exq.pop_front();
            chk("status", 32'(e.sv & e.sm), 32'(st & e.sm));
            chk("park", 32'(e.kv), 32'(park));
            if (e.pe) begin
                chk("position", e.pv, pos);
            end
        end
    end

    // about 150 cycles of traffic; 3000, some 20 times that, means a hang
    initial begin
        repeat (3000) @(posedge core_clk);
        failures++;
        close_out();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(77));
        {rst, position, ref_mark, probe1, probe2, enc_fault, fault_code} = '0;
        {failures, cmp_count, cyc, parked} = '0;
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        expect_at(1, 16'hFFFF, 16'h0000, 1'b1, 32'h0);
        repeat (2) @(negedge core_clk);
        for (int i = 0; i < 4; i++) begin
            {probe2, probe1} = 2'($urandom);
            expect_at(1, 16'h1700, {6'h0, probe2, probe1, 8'h0}, 1'b0, 32'h0);
            @(negedge core_clk);
        end
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 4; i++) begin
                sel = 4'h1 << i;
                {probe2, probe1} = {2{i[0]}};
                tx(mk(1'b0, 1'b0, 1'b0, f[0], ECSH_CMD_ACT, sel));
                expect_at(2, 16'h00FF, {12'h0, sel}, 1'b0, 32'h0);
                tx(mk(1'b0, 1'b0, 1'b0, f[0], ECSH_CMD_NONE, sel));
                // one edge on: the event below lands on the next edge and shows one edge later
                expect_at(1, 16'h00FF, {12'h0, sel}, 1'b0, 32'h0);
                position = $urandom;
                cap = position;
                if (f == 0) begin
                    ref_mark = sel;
                    @(negedge core_clk);
                    ref_mark = 4'h0;
                end else if (i < 2) begin
                    probe1 = ~probe1;
                end else begin
                    probe2 = ~probe2;
                end
                wait_bit(4 + i, 1'b1);
                expect_at(1, 16'h00FF, {8'h0, sel, 4'h0}, 1'b0, 32'h0);
                position = ~cap;
                tx(mk(1'b0, 1'b0, 1'b0, f[0], ECSH_CMD_READ, sel));
                expect_at(2, 16'h00F0, {8'h0, sel, 4'h0}, 1'b1, cap);
                tx(mk(1'b0, 1'b0, 1'b0, f[0], ECSH_CMD_STOP, sel));
                expect_at(2, 16'h00FF, 16'h0000, 1'b0, 32'h0);
            end
        end
        position = $urandom;
        tx(mk(1'b0, 1'b0, 1'b1, 1'b0, ECSH_CMD_NONE, 4'h0));
        expect_at(2, 16'hFC00, 16'h2000, 1'b1, position);
        tx(mk(1'b0, 1'b1, 1'b1, 1'b0, ECSH_CMD_NONE, 4'h0));
        parked = 1'b1;
        expect_at(2, 16'hFC00, 16'h4000, 1'b1, 32'h0);
        enc_fault = 1'b1;
        expect_at(3, 16'hFC00, 16'h4000, 1'b1, 32'h0);
        repeat (3) @(negedge core_clk);
        enc_fault = 1'b0;
        tx(mk(1'b0, 1'b0, 1'b0, 1'b0, ECSH_CMD_NONE, 4'h0));
        parked = 1'b0;
        expect_at(2, 16'hFC00, 16'h0000, 1'b1, 32'h0);
        repeat (2) @(negedge core_clk);
        fault_code = $urandom;
        enc_fault = 1'b1;
        @(negedge core_clk);
        enc_fault = 1'b0;
        expect_at(2, 16'hFC00, 16'h8000, 1'b1, fault_code);
        fault_code = ~fault_code;
        repeat (3) @(negedge core_clk);
        tx(mk(1'b1, 1'b0, 1'b0, 1'b0, ECSH_CMD_NONE, 4'h0));
        wait_bit(11, 1'b1);
        wait_bit(15, 1'b0);
        expect_at(1, 16'hFC00, 16'h0000, 1'b1, 32'h0);
        repeat (4) @(negedge core_clk);
        close_out();
    end
endmodule // ecsh_top_tb
`default_nettype wire
